// ### rtl/abg_pkg.sv
// constants shared by the async serial port, its baud timer and clock selector
// assumes a single 20 MHz clock and a plain address/strobe register port
//
// Overview of operation
// - full duplex, eight-bit and nine-bit variable modes
// - received byte buffered while next byte arrives
// - data buffer writes load transmit holding register
// - data buffer reads return received byte only
// - interrupt request on either done flag
// - done flags stay set until software clears
// - baud from eight-bit auto-reload timer
// - transmit bit clock from timer low counter
// - hidden receive counter shares reload byte
// - both overflow streams divided by two
// - start edge forces receive counter reload
// - timer clock from five selectable sources
// - baud equals timer clock over reload span, halved
// - eight-bit frame, stop bit into ninth field
// - nine-bit frame carries software ninth bit
// - load only when flag clear and filter passes
// - tx flag at stop start; receive needs enable
package abg_pkg;
   localparam int ABG_ADDR_W = 3;
   localparam logic [2:0] ABG_OFF_CTRL = 3'h0;
   localparam logic [2:0] ABG_OFF_DATA = 3'h1;
   localparam logic [2:0] ABG_OFF_TMR = 3'h2;
   localparam logic [2:0] ABG_OFF_RELOAD = 3'h3;
   localparam logic [2:0] ABG_OFF_LOW = 3'h4;
   // serial_control_reg fields
   localparam int ABG_CTRL_MODE = 7;
   localparam int ABG_CTRL_ONE = 6;
   localparam int ABG_CTRL_MCE = 5;
   localparam int ABG_CTRL_REN = 4;
   localparam int ABG_CTRL_TB8 = 3;
   localparam int ABG_CTRL_RB8 = 2;
   localparam int ABG_CTRL_TI = 1;
   localparam int ABG_CTRL_RI = 0;
   localparam logic [7:0] ABG_CTRL_RST = 8'h40;
   localparam logic [7:0] ABG_DATA_RST = 8'h00;
   // timer control fields
   localparam int ABG_TMR_RUN = 0;
   localparam int ABG_TMR_SEL_LO = 1;
   localparam int ABG_TMR_IE = 7;
   localparam logic [7:0] ABG_TMR_RST = 8'h00;
   localparam logic [7:0] ABG_RELOAD_RST = 8'h00;
   localparam logic [7:0] ABG_CNT_MAX = 8'hFF;
   // clock source codes
   localparam logic [2:0] ABG_SEL_DIV4 = 3'h0;
   localparam logic [2:0] ABG_SEL_DIV12 = 3'h1;
   localparam logic [2:0] ABG_SEL_DIV48 = 3'h2;
   localparam logic [2:0] ABG_SEL_OSC8 = 3'h3;
   localparam logic [2:0] ABG_SEL_PIN = 3'h4;
   localparam int ABG_DIV_A = 4;
   localparam int ABG_DIV_B = 12;
   localparam int ABG_DIV_C = 48;
   localparam int ABG_DIV_OSC = 8;
   localparam logic [3:0] ABG_DATA_BITS = 4'h8;
endpackage

// ### rtl/abg_tick_if.sv
// bundle between the port and one eight-bit reload counter
// assumes all members change on the rising edge of the one clock
`timescale 1ns/1ps
interface abg_tick_if;
   logic tick;
   logic reload_force;
   logic load_we;
   logic [7:0] load_val;
   logic [7:0] reload;
   logic [7:0] count;
   logic ovf;
   modport timer (input tick, reload_force, load_we, load_val, reload, output count, ovf);
   modport ctrl (output tick, reload_force, load_we, load_val, reload, input count, ovf);
endinterface

// ### rtl/abg_clk_sel.sv
// timer clock enable selector: three system divides, oscillator divide, pin
// assumes external oscillator and pin inputs already synchronous to clk_i
`timescale 1ns/1ps
module abg_clk_sel
   import abg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] sel_i,
   input wire logic ext_osc_i,
   input wire logic ext_pin_i,
   output logic tick_o
);
   logic [1:0] cnt_a;
   logic [3:0] cnt_b;
   logic [5:0] cnt_c;
   logic [2:0] cnt_o;
   logic osc_prev;
   logic pin_prev;
   wire end_a = (cnt_a == 2'(ABG_DIV_A - 1));
   wire end_b = (cnt_b == 4'(ABG_DIV_B - 1));
   wire end_c = (cnt_c == 6'(ABG_DIV_C - 1));
   wire osc_rise = ext_osc_i & ~osc_prev;
   wire end_o = osc_rise & (cnt_o == 3'(ABG_DIV_OSC - 1));
   wire pin_rise = ext_pin_i & ~pin_prev;
   wire next_tick = (sel_i == ABG_SEL_DIV4) ? end_a :
                    (sel_i == ABG_SEL_DIV12) ? end_b :
                    (sel_i == ABG_SEL_DIV48) ? end_c :
                    (sel_i == ABG_SEL_OSC8) ? end_o :
                    (sel_i == ABG_SEL_PIN) ? pin_rise : 1'b0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_a <= '0;
         cnt_b <= '0;
         cnt_c <= '0;
         cnt_o <= '0;
         // track the inputs so a high level at reset exit is no edge
         osc_prev <= ext_osc_i;
         pin_prev <= ext_pin_i;
         tick_o <= 1'b0;
      end else begin
         cnt_a <= end_a ? 2'h0 : cnt_a + 2'h1;
         cnt_b <= end_b ? 4'h0 : cnt_b + 4'h1;
         cnt_c <= end_c ? 6'h00 : cnt_c + 6'h01;
         if (osc_rise) cnt_o <= cnt_o + 3'h1;
         osc_prev <= ext_osc_i;
         pin_prev <= ext_pin_i;
         tick_o <= next_tick;
      end
   end
endmodule // abg_clk_sel

// ### rtl/abg_reload_cnt.sv
// eight-bit up counter with automatic reload on overflow
// assumes tick is a one-cycle enable from the clock selector
`timescale 1ns/1ps
module abg_reload_cnt
   import abg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   abg_tick_if.timer bus
);
   wire wrap = bus.tick & (bus.count == ABG_CNT_MAX);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus.count <= '0;
         bus.ovf <= 1'b0;
      end else begin
         bus.ovf <= wrap & ~bus.load_we & ~bus.reload_force;
         if (bus.load_we) begin
            bus.count <= bus.load_val;
         end else if (bus.reload_force | wrap) begin
            bus.count <= bus.reload;
         end else if (bus.tick) begin
            bus.count <= bus.count + 8'h01;
         end
      end
   end
endmodule // abg_reload_cnt

// ### rtl/abg_async_port.sv
// async serial port with its reload-timer baud generator and register port
// assumes rx_i and register strobes synchronous to clk_i, strobes never overlap
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module abg_async_port
   import abg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ABG_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   input wire logic ext_osc_i,
   input wire logic baud_timer_ext_input_i,
   input wire logic rx_i,
   output logic tx_o,
   output logic irq_o
);
   typedef enum logic [2:0] {ABG_IDLE, ABG_START, ABG_DATA, ABG_NINTH, ABG_STOP} abg_state_t;

   // register state
   logic frame_mode_select;
   logic multiproc_filter_enable;
   logic rx_enable_bit;
   logic tx_ninth_bit;
   logic rx_ninth_bit;
   logic tx_done_flag;
   logic rx_done_flag;
   logic [7:0] serial_data_buffer;
   logic [7:0] tmr_ctrl;
   logic [7:0] baud_timer_reload_byte;

   // transmit state
   abg_state_t tx_state;
   logic [7:0] tx_hold;
   logic tx_pending;
   logic [7:0] tx_shift;
   logic [3:0] tx_cnt;
   logic tx_div;

   // receive state
   abg_state_t rx_state;
   logic [7:0] rx_shift;
   logic [3:0] rx_cnt;
   logic rx_nb;
   logic rx_div;
   logic rx_prev;

   logic timer_tick;

   abg_tick_if tx_bus ();
   abg_tick_if rx_bus ();

   // decode
   wire sel_ctrl = (addr_i == ABG_OFF_CTRL);
   wire sel_data = (addr_i == ABG_OFF_DATA);
   wire sel_tmr = (addr_i == ABG_OFF_TMR);
   wire sel_reload = (addr_i == ABG_OFF_RELOAD);
   wire sel_low = (addr_i == ABG_OFF_LOW);
   wire wr_ctrl = wr_i & sel_ctrl;
   wire wr_data = wr_i & sel_data;
   wire wr_tmr = wr_i & sel_tmr;
   wire wr_reload = wr_i & sel_reload;
   wire wr_low = wr_i & sel_low;
   wire timer_run = tmr_ctrl[ABG_TMR_RUN];
   wire irq_en = tmr_ctrl[ABG_TMR_IE];
   wire [2:0] clk_src = tmr_ctrl[ABG_TMR_SEL_LO +: 3];
   wire mode9 = frame_mode_select;

   wire [7:0] ctrl_view = {frame_mode_select, 1'b1, multiproc_filter_enable, rx_enable_bit,
                           tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
   // the transmit holding register has no read path at all
   wire [7:0] next_rd_data = sel_ctrl ? ctrl_view :
                             sel_data ? serial_data_buffer :
                             sel_tmr ? tmr_ctrl :
                             sel_reload ? baud_timer_reload_byte :
                             sel_low ? tx_bus.count : 8'h00;

   // baud generation
   abg_clk_sel u_clk_sel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(clk_src),
      .ext_osc_i(ext_osc_i),
      .ext_pin_i(baud_timer_ext_input_i),
      .tick_o(timer_tick)
   );

   wire rx_start_edge = (rx_state == ABG_IDLE) & rx_enable_bit & rx_prev & ~rx_i;

   assign tx_bus.tick = timer_tick & timer_run;
   assign tx_bus.reload_force = 1'b0;
   assign tx_bus.load_we = wr_low; // software sees only the transmit counter
   assign tx_bus.load_val = wr_data_i;
   assign tx_bus.reload = baud_timer_reload_byte;

   assign rx_bus.tick = timer_tick & timer_run;
   assign rx_bus.reload_force = rx_start_edge;
   assign rx_bus.load_we = 1'b0;
   assign rx_bus.load_val = 8'h00;
   assign rx_bus.reload = baud_timer_reload_byte;

   abg_reload_cnt u_tx_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(tx_bus.timer)
   );

   abg_reload_cnt u_rx_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(rx_bus.timer)
   );

   // bit rate is overflow rate halved, so timer clock / (256 - reload) / 2
   wire tx_bit = tx_bus.ovf & tx_div;
   // receive samples on odd overflows after the forced reload: first one lands mid start bit
   wire rx_sample = rx_bus.ovf & ~rx_div;

   // transmit side
   wire tx_go = (tx_state == ABG_IDLE) & tx_pending & tx_bit;
   wire tx_last = (tx_cnt == ABG_DATA_BITS - 4'h1);
   wire tx_set = tx_bit & (((tx_state == ABG_DATA) & tx_last & ~mode9) |
                           (tx_state == ABG_NINTH));

   // receive side
   wire rx_last = (rx_cnt == ABG_DATA_BITS - 4'h1);
   wire rx_end = rx_sample & (rx_state == ABG_STOP);
   wire rx_check = mode9 ? rx_nb : rx_i;
   wire rx_accept = rx_end & ~rx_done_flag & (~multiproc_filter_enable | rx_check);

   // flags: hardware set wins over a software clear in the same cycle
   wire next_tx_done = tx_set | (wr_ctrl ? wr_data_i[ABG_CTRL_TI] : tx_done_flag);
   wire next_rx_done = rx_accept | (wr_ctrl ? wr_data_i[ABG_CTRL_RI] : rx_done_flag);
   wire next_irq = irq_en & (next_tx_done | next_rx_done);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_mode_select <= ABG_CTRL_RST[ABG_CTRL_MODE];
         multiproc_filter_enable <= ABG_CTRL_RST[ABG_CTRL_MCE];
         rx_enable_bit <= ABG_CTRL_RST[ABG_CTRL_REN];
         tx_ninth_bit <= ABG_CTRL_RST[ABG_CTRL_TB8];
         tmr_ctrl <= ABG_TMR_RST;
         baud_timer_reload_byte <= ABG_RELOAD_RST;
      end else begin
         if (wr_ctrl) begin
            frame_mode_select <= wr_data_i[ABG_CTRL_MODE];
            multiproc_filter_enable <= wr_data_i[ABG_CTRL_MCE];
            rx_enable_bit <= wr_data_i[ABG_CTRL_REN];
            tx_ninth_bit <= wr_data_i[ABG_CTRL_TB8];
         end
         if (wr_tmr) tmr_ctrl <= wr_data_i;
         if (wr_reload) baud_timer_reload_byte <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_done_flag <= ABG_CTRL_RST[ABG_CTRL_TI];
         rx_done_flag <= ABG_CTRL_RST[ABG_CTRL_RI];
         irq_o <= 1'b0;
         rd_data_o <= 8'h00;
      end else begin
         tx_done_flag <= next_tx_done;
         rx_done_flag <= next_rx_done;
         irq_o <= next_irq;
         rd_data_o <= rd_i ? next_rd_data : 8'h00;
      end
   end

   // receive buffer and ninth field; software may also write the ninth field
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_data_buffer <= ABG_DATA_RST;
         rx_ninth_bit <= ABG_CTRL_RST[ABG_CTRL_RB8];
      end else if (rx_accept) begin
         serial_data_buffer <= rx_shift;
         rx_ninth_bit <= rx_check;
      end else if (wr_ctrl) begin
         rx_ninth_bit <= wr_data_i[ABG_CTRL_RB8];
      end
   end

   // transmit holding register and divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_hold <= 8'h00;
         tx_pending <= 1'b0;
         tx_div <= 1'b0;
      end else begin
         if (tx_bus.ovf) tx_div <= ~tx_div;
         if (wr_data) begin
            tx_hold <= wr_data_i;
            tx_pending <= 1'b1;
         end else if (tx_go) begin
            tx_pending <= 1'b0;
         end
      end
   end

   // transmit sequencer: frames start on a bit boundary of the transmit clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_state <= ABG_IDLE;
         tx_shift <= 8'h00;
         tx_cnt <= 4'h0;
         tx_o <= 1'b1;
      end else if (tx_bit) begin
         case (tx_state)
            ABG_IDLE: begin
               if (tx_pending) begin
                  tx_shift <= tx_hold;
                  tx_o <= 1'b0;
                  tx_state <= ABG_START;
               end
            end
            ABG_START: begin
               tx_o <= tx_shift[0];
               tx_shift <= {1'b0, tx_shift[7:1]};
               tx_cnt <= 4'h0;
               tx_state <= ABG_DATA;
            end
            ABG_DATA: begin
               if (tx_last) begin
                  if (mode9) begin
                     tx_o <= tx_ninth_bit;
                     tx_state <= ABG_NINTH;
                  end else begin
                     tx_o <= 1'b1;
                     tx_state <= ABG_STOP;
                  end
               end else begin
                  tx_o <= tx_shift[0];
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_cnt <= tx_cnt + 4'h1;
               end
            end
            ABG_NINTH: begin
               tx_o <= 1'b1;
               tx_state <= ABG_STOP;
            end
            ABG_STOP: begin
               tx_state <= ABG_IDLE;
            end
            default: begin
               tx_o <= 1'b1;
               tx_state <= ABG_IDLE;
            end
         endcase
      end
   end

   // receive sequencer; a high start sample is a glitch and is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_state <= ABG_IDLE;
         rx_shift <= 8'h00;
         rx_cnt <= 4'h0;
         rx_nb <= 1'b0;
         rx_div <= 1'b0;
         rx_prev <= 1'b1;
      end else begin
         rx_prev <= rx_i;
         if (rx_start_edge) begin
            rx_div <= 1'b0;
            rx_state <= ABG_START;
         end else begin
            if (rx_bus.ovf) rx_div <= ~rx_div;
            if (rx_sample) begin
               case (rx_state)
                  ABG_IDLE: begin
                     rx_state <= ABG_IDLE;
                  end
                  ABG_START: begin
                     rx_cnt <= 4'h0;
                     rx_state <= rx_i ? ABG_IDLE : ABG_DATA;
                  end
                  ABG_DATA: begin
                     rx_shift <= {rx_i, rx_shift[7:1]};
                     rx_cnt <= rx_cnt + 4'h1;
                     if (rx_last) rx_state <= mode9 ? ABG_NINTH : ABG_STOP;
                  end
                  ABG_NINTH: begin
                     rx_nb <= rx_i;
                     rx_state <= ABG_STOP;
                  end
                  ABG_STOP: begin
                     rx_state <= ABG_IDLE;
                  end
                  default: begin
                     rx_state <= ABG_IDLE;
                  end
               endcase
            end
         end
      end
   end
endmodule // abg_async_port

// ### tb/abg_async_port_monitor.sv
// assertions on the async serial port top ports
// assumes bind onto abg_async_port, one clock, synchronous reset
`timescale 1ns/1ps
module abg_async_port_monitor
   import abg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ABG_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rd_data_o,
   input wire logic tx_o,
   input wire logic irq_o
);
   logic wrote;
   wire data_wr = wr_i && (addr_i == ABG_OFF_DATA);
   always_ff @(posedge clk_i) begin
      if (rst_i) wrote <= 1'b0;
      else if (data_wr) wrote <= 1'b1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rd_idle; !$past(rd_i) |-> rd_data_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
   property p_rst_exit; $fell(rst_i) |-> tx_o && !irq_o; endproperty
   a_rst_exit: assert property (p_rst_exit) else $error("line or irq wrong after reset");
   property p_ctrl_one; rd_i && addr_i == ABG_OFF_CTRL |=> rd_data_o[ABG_CTRL_ONE]; endproperty
   a_ctrl_one: assert property (p_ctrl_one) else $error("fixed control bit not one");
   property p_unmapped; rd_i && addr_i > ABG_OFF_LOW |=> rd_data_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_irq_off;
      wr_i && addr_i == ABG_OFF_TMR && !wr_data_i[ABG_TMR_IE] |-> ##2 !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_irq_flags;
      rd_i && addr_i == ABG_OFF_CTRL ##1 rd_data_o[1:0] == 2'h0 |-> !$past(irq_o);
   endproperty
   a_irq_flags: assert property (p_irq_flags) else $error("irq without a flag");
   property p_start_min; $fell(tx_o) |-> (!tx_o) [*4]; endproperty
   a_start_min: assert property (p_start_min) else $error("start bit too short");
   property p_tx_cause; $fell(tx_o) |-> wrote; endproperty
   a_tx_cause: assert property (p_tx_cause) else $error("frame without data write");
endmodule // abg_async_port_monitor

bind abg_async_port abg_async_port_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
   .rd_data_o(rd_data_o), .tx_o(tx_o), .irq_o(irq_o));

// ### tb/abg_remote_xcvr.sv
// remote async transceiver: sends frames on rx line, decodes tx line
// assumes bit time in clocks given by the bench, idle line high
`timescale 1ns/1ps
module abg_remote_xcvr (
   input wire logic clk_i,
   input wire logic tx_i,
   input wire logic nine_i,
   input wire logic [15:0] bit_cyc_i,
   output logic rx_o
);
   logic [7:0] got_data;
   logic got_ninth;
   logic got_stop;
   int got_cnt;
   int i;
   initial rx_o = 1'b1;
   task automatic send(input logic [7:0] d, input logic nine, input logic b9);
      logic [10:0] fr;
      int k;
      fr = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
      for (k = 0; k < (nine ? 11 : 10); k++) begin
         @(posedge clk_i);
         rx_o <= fr[k];
         repeat (bit_cyc_i - 1) @(posedge clk_i);
      end
      repeat (bit_cyc_i) @(posedge clk_i);
   endtask
   // sampled on the falling clock edge, clear of the line's launch edge
   initial begin
      got_cnt = 0;
      forever begin
         @(negedge clk_i);
         if (tx_i === 1'b0) begin
            repeat (bit_cyc_i / 2) @(negedge clk_i);
            for (i = 0; i < 8; i++) begin
               repeat (bit_cyc_i) @(negedge clk_i);
               got_data[i] = tx_i;
            end
            if (nine_i) begin
               repeat (bit_cyc_i) @(negedge clk_i);
               got_ninth = tx_i;
            end
            repeat (bit_cyc_i) @(negedge clk_i);
            got_stop = tx_i;
            got_cnt++;
         end
      end
   end
endmodule // abg_remote_xcvr

// ### tb/async_serial_port_baud_gen_tb_top.sv
// register-level tests of the async serial port against a remote model
// assumes 50 ns clock; bench toggles both external timer inputs freely
`timescale 1ns/1ps
module async_serial_port_baud_gen_tb_top;
   import abg_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] addr_i;
   logic [7:0] wr_data_i, rd_data, rv;
   logic wr_i, rd_i, rx, tx, irq, nine;
   logic [15:0] bit_cyc;
   logic [1:0] ext_cnt = 2'h0;
   logic [2:0] sels [5] = '{ABG_SEL_DIV4, ABG_SEL_DIV12, ABG_SEL_DIV48,
      ABG_SEL_OSC8, ABG_SEL_PIN};
   // osc rises every 2 clocks, pin every 4: distinct rates catch swapped inputs
   int divs [5] = '{ABG_DIV_A, ABG_DIV_B, ABG_DIV_C, 2 * ABG_DIV_OSC, 4};
   int error_cnt = 0;
   int tests_run = 0;
   int s;
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) ext_cnt <= ext_cnt + 2'h1;
   abg_async_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data), .ext_osc_i(ext_cnt[0]),
      .baud_timer_ext_input_i(ext_cnt[1]), .rx_i(rx), .tx_o(tx), .irq_o(irq));
   abg_remote_xcvr partner_u (.clk_i(clk_i), .tx_i(tx), .nine_i(nine), .bit_cyc_i(bit_cyc),
      .rx_o(rx));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [2:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rv = rd_data;
   endtask
   task rd_chk(input logic [2:0] a, input logic [7:0] exp);
      rd(a);
      chk(rv, exp);
   endtask
   task wait_ctrl(input logic [7:0] m);
      int n;
      n = 0;
      rd(ABG_OFF_CTRL);
      while ((rv & m) === 8'h00 && n < 3000) begin
         rd(ABG_OFF_CTRL);
         n++;
      end
   endtask
   task wait_tx(input int n);
      int k;
      k = 0;
      while (partner_u.got_cnt < n && k < 5000) begin
         @(posedge clk_i);
         k++;
      end
   endtask
   task idle(input int bits);
      repeat (bits * bit_cyc) @(posedge clk_i);
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      error_cnt++;
      wrap_up();
   end
   initial begin
      addr_i = 3'h0;
      wr_data_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      nine = 1'b0;
      bit_cyc = 16'd16;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(ABG_OFF_CTRL, ABG_CTRL_RST);
      rd_chk(ABG_OFF_DATA, ABG_DATA_RST);
      rd_chk(ABG_OFF_TMR, ABG_TMR_RST);
      rd_chk(ABG_OFF_RELOAD, ABG_RELOAD_RST);
      rd_chk(ABG_OFF_LOW, 8'h00);
      wr(ABG_OFF_LOW, 8'h12);
      rd_chk(ABG_OFF_LOW, 8'h12);
      wr(3'h5, 8'hFF);
      rd_chk(3'h5, 8'h00);
      $display("reset test done");
      wr(ABG_OFF_RELOAD, 8'hFE);
      rd_chk(ABG_OFF_RELOAD, 8'hFE);
      wr(ABG_OFF_CTRL, 8'h10);
      // one bit is two overflows of two ticks at each divide
      for (s = 0; s < 5; s++) begin
         bit_cyc = 16'(4 * divs[s]);
         wr(ABG_OFF_TMR, {1'b1, 3'b000, sels[s], 1'b1});
         wr(ABG_OFF_DATA, 8'hA5 ^ 8'(s));
         wait_tx(s + 1);
         chk(partner_u.got_data, 8'hA5 ^ 8'(s));
         chk({7'h00, partner_u.got_stop}, 8'h01);
         wait_ctrl(8'h02);
         chk(rv, 8'h52);
         chk({7'h00, irq}, 8'h01);
         rd_chk(ABG_OFF_DATA, 8'h00);
         rd_chk(ABG_OFF_CTRL, 8'h52);
         wr(ABG_OFF_CTRL, 8'h10);
         rd_chk(ABG_OFF_CTRL, 8'h50);
         chk({7'h00, irq}, 8'h00);
         idle(2);
      end
      $display("transmit test done");
      bit_cyc = 16'd16;
      wr(ABG_OFF_TMR, {1'b1, 3'b000, ABG_SEL_DIV4, 1'b1});
      partner_u.send(8'h3C, 1'b0, 1'b0);
      wait_ctrl(8'h01);
      chk(rv, 8'h55);
      partner_u.send(8'hC3, 1'b0, 1'b0);
      rd_chk(ABG_OFF_DATA, 8'h3C);
      wr(ABG_OFF_CTRL, 8'h00);
      partner_u.send(8'h77, 1'b0, 1'b0);
      rd_chk(ABG_OFF_CTRL, 8'h40);
      $display("receive test done");
      nine = 1'b1;
      wr(ABG_OFF_CTRL, 8'h98);
      wr(ABG_OFF_DATA, 8'h81);
      wait_tx(6);
      chk(partner_u.got_data, 8'h81);
      chk({7'h00, partner_u.got_ninth}, 8'h01);
      wait_ctrl(8'h02);
      wr(ABG_OFF_CTRL, 8'hB8);
      partner_u.send(8'h22, 1'b1, 1'b0);
      rd_chk(ABG_OFF_CTRL, 8'hF8);
      partner_u.send(8'h44, 1'b1, 1'b1);
      wait_ctrl(8'h01);
      chk(rv, 8'hFD);
      rd_chk(ABG_OFF_DATA, 8'h44);
      wr(ABG_OFF_TMR, {1'b0, 3'b000, ABG_SEL_DIV4, 1'b1});
      repeat (2) @(posedge clk_i);
      #1 chk({7'h00, irq}, 8'h00);
      $display("nine-bit test done");
      wrap_up();
   end
endmodule // async_serial_port_baud_gen_tb_top
